// ===== rtl/epp_core.sv
// Encoder position parameter logic with Wishbone register slave
// How it works
// - Class 4 applies configured direction, and resolution and range when scaling is on, to the position computation.
// - Class 3 disables scaling regardless of configured scaling.
// - Class 3 forces steps per revolution to native resolution.
// - Class 3 forces total range to native range.
// - Class 3 always counts clockwise.
// - Class 3 ignores preset requests.
// - V3.1 mode applies configured sign-of-life failure limit.
// - V3.1 mode reports control request bit as zero.
// - V3.1 mode accepts control words regardless of control bit.
// - V3.1 mode presets only the second position value.
// - Resolution must lie between one and native maximum.
// - Resolution change clears stored preset offset.
// - Total range between two and resolution times max revolutions.
// - Total range change clears stored preset offset.
// - Values ascend clockwise or counter-clockwise as selected.
// - Resolution, range, direction honoured only in class 4.
// - Preset option selects both values or only the second.
// - Scaling off uses native resolution and range.
`timescale 1ns/1ps
`default_nettype none
module epp_core
   import epp_pkg::*;
#(
   parameter int unsigned ST_BITS = EPP_ST_BITS,
   parameter int unsigned MT_BITS = EPP_MT_BITS
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [EPP_POS_BITS-1:0] raw_pos_i,
   input wire logic life_tick_i,
   input wire logic life_ok_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic param_err_o,
   output logic life_fail_o
);
   localparam int unsigned RB = EPP_RNG_BITS;
   localparam int unsigned LB = RB + MT_BITS + 1;

   // Byte-lane merge of a write word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Reduce a wide value by one subtraction of the range when at or above it (range fits RB bits)
   function automatic logic [RB-1:0] wrap(input logic [RB:0] v, input logic [RB-1:0] m);
      logic [RB:0] t;
      t = v;
      if (t >= {1'b0, m})
      begin
         t = t - {1'b0, m};
      end
      return t[RB-1:0];
   endfunction

   logic [31:0] cfg_q, cfg_d;
   logic [RB-1:0] res_q, res_d;
   logic [RB-1:0] tmr_q, tmr_d;
   logic [RB-1:0] off1_q, off1_d;
   logic [RB-1:0] off2_q, off2_d;
   logic [RB-1:0] pos1_q, pos1_d;
   logic [RB-1:0] pos2_q, pos2_d;
   logic [31:0] ctrl_q, ctrl_d;
   logic perr_q, perr_d;
   logic [7:0] lcnt_q, lcnt_d;
   logic lfail_q, lfail_d;
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   epp_cfg_t cfg;
   epp_eff_t eff;
   logic req;
   logic [RB-1:0] wval;
   logic wval_fits;
   logic [RB+MT_BITS:0] tmr_lim;
   logic [RB-1:0] scaled;
   logic [RB-1:0] dir_pos;
   logic [RB-1:0] preset_val;
   logic ctrl_accept;

   assign cfg.class4 = cfg_q[EPP_B_CLASS4];
   assign cfg.compat_v31 = cfg_q[EPP_B_COMPAT];
   assign cfg.counterclockwise_counting = cfg_q[EPP_B_CCW];
   assign cfg.scale_on = cfg_q[EPP_B_SCALE];
   assign cfg.preset_affects_first = cfg_q[EPP_B_PAFF1];
   assign cfg.life_limit = cfg_q[EPP_B_LIFE +: 8];

   epp_eff_sel u_eff
   (
      .cfg_i(cfg),
      .res_i(res_q),
      .tmr_i(tmr_q),
      .eff_o(eff)
   );

   // Bus request and range checks
   assign req = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wval = wb_dat_i[RB-1:0];
   assign wval_fits = (wb_dat_i[31:RB] == '0); // Upper bits must not alias a legal value
   assign tmr_lim = LB'(res_q) * LB'(EPP_REV_MAX);
   // Control word accepted in V3.1 mode or when controller holds control
   assign ctrl_accept = cfg.compat_v31 | ctrl_q[EPP_B_CP];

   // Scale native position into the effective range and direction
   always_comb
   begin
      logic [2*RB-1:0] prod;
      prod = '0;
      prod = (2*RB)'(raw_pos_i) * (2*RB)'(eff.res);
      scaled = RB'((prod >> ST_BITS) % (2*RB)'(eff.tmr));
      if (eff.counterclockwise_counting)
      begin
         dir_pos = (scaled == '0) ? '0 : RB'(eff.tmr - scaled);
      end
      else
      begin
         dir_pos = scaled;
      end
   end

   // Offset to make the current position equal the written preset
   assign preset_val = wrap({1'b0, wval} + {1'b0, eff.tmr} - {1'b0, dir_pos}, eff.tmr);

   // Register file, presets and parameter checking
   always_comb
   begin
      cfg_d = cfg_q;
      res_d = res_q;
      tmr_d = tmr_q;
      off1_d = off1_q;
      off2_d = off2_q;
      ctrl_d = ctrl_q;
      perr_d = perr_q;
      if (req && wb_we_i)
      begin
         case (wb_adr_i)
            EPP_A_CFG: cfg_d = merge(cfg_q, wb_dat_i, wb_sel_i);
            EPP_A_RES:
            begin
               if (wval_fits && wval >= EPP_RES_MIN && wval <= EPP_ST_MAX)
               begin
                  res_d = wval;
                  if (wval != res_q)
                  begin
                     off1_d = '0;
                     off2_d = '0;
                  end
               end
               else
               begin
                  perr_d = 1'b1;
               end
            end
            EPP_A_TMR:
            begin
               if (wval_fits && wval >= EPP_TMR_MIN && LB'(wval) <= tmr_lim)
               begin
                  tmr_d = wval;
                  if (wval != tmr_q)
                  begin
                     off1_d = '0;
                     off2_d = '0;
                  end
               end
               else
               begin
                  perr_d = 1'b1;
               end
            end
            EPP_A_PRESET:
            begin
               if (eff.preset_ok && ctrl_accept)
               begin
                  off2_d = preset_val;
                  if (cfg.preset_affects_first && !cfg.compat_v31)
                  begin
                     off1_d = preset_val;
                  end
               end
            end
            EPP_A_CTRL: ctrl_d = merge(ctrl_q, wb_dat_i, wb_sel_i);
            EPP_A_STAT:
            begin
               if (wb_dat_i[EPP_B_PERR])
               begin
                  perr_d = 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   // Position outputs with their own offsets
   always_comb
   begin
      pos1_d = wrap({1'b0, dir_pos} + {1'b0, off1_q}, eff.tmr);
      pos2_d = wrap({1'b0, dir_pos} + {1'b0, off2_q}, eff.tmr);
   end

   // Sign-of-life failure counting against the configured limit
   always_comb
   begin
      lcnt_d = lcnt_q;
      lfail_d = lfail_q;
      // Write-one clear first, so a failure in the same cycle wins
      if (req && wb_we_i && wb_adr_i == EPP_A_STAT && wb_dat_i[EPP_B_LIFEF])
      begin
         lfail_d = 1'b0;
      end
      if (life_tick_i)
      begin
         if (life_ok_i)
         begin
            lcnt_d = '0;
         end
         else if (cfg.compat_v31 && cfg.life_limit != EPP_LIFE_OFF)
         begin
            if (lcnt_q != 8'hff)
            begin
               lcnt_d = lcnt_q + 8'h01;
            end
            if (lcnt_q >= cfg.life_limit)
            begin
               lfail_d = 1'b1;
            end
         end
      end
   end

   // Ack and read data
   always_comb
   begin
      ack_d = req;
      rdat_d = '0;
      if (req && !wb_we_i)
      begin
         case (wb_adr_i)
            EPP_A_CFG: rdat_d = cfg_q;
            EPP_A_RES: rdat_d = 32'(res_q);
            EPP_A_TMR: rdat_d = 32'(tmr_q);
            EPP_A_CTRL: rdat_d = ctrl_q;
            EPP_A_STAT:
            begin
               rdat_d[EPP_B_CR] = ctrl_q[EPP_B_CP] & ~cfg.compat_v31;
               rdat_d[EPP_B_PERR] = perr_q;
               rdat_d[EPP_B_LIFEF] = lfail_q;
            end
            EPP_A_POS1: rdat_d = 32'(pos1_q);
            EPP_A_POS2: rdat_d = 32'(pos2_q);
            default: rdat_d = '0;
         endcase
      end
   end

   // State registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_q <= EPP_CFG_RST;
         res_q <= EPP_ST_MAX;
         tmr_q <= EPP_TMR_MAX;
         off1_q <= '0;
         off2_q <= '0;
         pos1_q <= '0;
         pos2_q <= '0;
         ctrl_q <= '0;
         perr_q <= 1'b0;
         lcnt_q <= '0;
         lfail_q <= 1'b0;
         ack_q <= 1'b0;
         rdat_q <= '0;
      end
      else if (ce_i)
      begin
         cfg_q <= cfg_d;
         res_q <= res_d;
         tmr_q <= tmr_d;
         off1_q <= off1_d;
         off2_q <= off2_d;
         pos1_q <= pos1_d;
         pos2_q <= pos2_d;
         ctrl_q <= ctrl_d;
         perr_q <= perr_d;
         lcnt_q <= lcnt_d;
         lfail_q <= lfail_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign param_err_o = perr_q;
   assign life_fail_o = lfail_q;
endmodule
`default_nettype wire

// ===== rtl/epp_eff_sel.sv
// Effective parameter selection from encoder class and scaling settings
`timescale 1ns/1ps
`default_nettype none
module epp_eff_sel
   import epp_pkg::*;
(
   input wire epp_cfg_t cfg_i,
   input wire logic [EPP_RNG_BITS-1:0] res_i,
   input wire logic [EPP_RNG_BITS-1:0] tmr_i,
   output epp_eff_t eff_o
);
   // Class 3 forces native values and clockwise; scaling off in class 4 forces native values only
   always_comb
   begin
      eff_o.preset_ok = cfg_i.class4;
      eff_o.counterclockwise_counting = cfg_i.class4 & cfg_i.counterclockwise_counting;
      if (cfg_i.class4 && cfg_i.scale_on)
      begin
         eff_o.res = res_i;
         eff_o.tmr = tmr_i;
      end
      else
      begin
         eff_o.res = EPP_ST_MAX;
         eff_o.tmr = EPP_TMR_MAX;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/epp_pkg.sv
// Package of constants and types for the encoder position parameter logic
package epp_pkg;
   localparam int unsigned EPP_ST_BITS = 13;
   localparam int unsigned EPP_MT_BITS = 16;
   localparam int unsigned EPP_POS_BITS = EPP_ST_BITS + EPP_MT_BITS;
   localparam int unsigned EPP_RNG_BITS = EPP_POS_BITS + 1;
   localparam logic [EPP_RNG_BITS-1:0] EPP_ST_MAX = 30'h0000_2000;
   localparam logic [EPP_RNG_BITS-1:0] EPP_TMR_MAX = 30'h2000_0000;
   localparam logic [EPP_RNG_BITS-1:0] EPP_RES_MIN = 30'h0000_0001;
   localparam logic [EPP_RNG_BITS-1:0] EPP_TMR_MIN = 30'h0000_0002;
   localparam logic [EPP_MT_BITS:0] EPP_REV_MAX = 17'h1_0000;
   localparam logic [7:0] EPP_LIFE_OFF = 8'hff;
   localparam logic [7:0] EPP_LIFE_DEF = 8'h01;
   // Wishbone word offsets
   localparam logic [7:0] EPP_A_CFG = 8'h00;
   localparam logic [7:0] EPP_A_RES = 8'h04;
   localparam logic [7:0] EPP_A_TMR = 8'h08;
   localparam logic [7:0] EPP_A_PRESET = 8'h0c;
   localparam logic [7:0] EPP_A_CTRL = 8'h10;
   localparam logic [7:0] EPP_A_STAT = 8'h14;
   localparam logic [7:0] EPP_A_POS1 = 8'h18;
   localparam logic [7:0] EPP_A_POS2 = 8'h1c;
   // Config field positions
   localparam int unsigned EPP_B_CLASS4 = 0;
   localparam int unsigned EPP_B_COMPAT = 1;
   localparam int unsigned EPP_B_CCW = 2;
   localparam int unsigned EPP_B_SCALE = 3;
   localparam int unsigned EPP_B_PAFF1 = 4;
   localparam int unsigned EPP_B_LIFE = 8;
   // Control / status bit positions
   localparam int unsigned EPP_B_CP = 0;
   localparam int unsigned EPP_B_CR = 0;
   localparam int unsigned EPP_B_PERR = 1;
   localparam int unsigned EPP_B_LIFEF = 2;
   localparam logic [31:0] EPP_CFG_RST = 32'h0000_0119;
   typedef struct packed {
      logic class4;
      logic compat_v31;
      logic counterclockwise_counting;
      logic scale_on;
      logic preset_affects_first;
      logic [7:0] life_limit;
   } epp_cfg_t;
   typedef struct packed {
      logic [EPP_RNG_BITS-1:0] res;
      logic [EPP_RNG_BITS-1:0] tmr;
      logic counterclockwise_counting;
      logic preset_ok;
   } epp_eff_t;
endpackage

// ===== testbench/epp_core_asserts.sv
// Port assertions for the encoder position core
`timescale 1ns/1ps
`default_nettype none
module epp_core_asserts
   import epp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic param_err_o,
   input wire logic life_fail_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   logic tk;
   logic wst;
   // Taken request and status write
   assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   assign wst = tk && wb_we_i && wb_adr_i == EPP_A_STAT;
   sequence s_wr(a);
      tk && wb_we_i && wb_adr_i == a;
   endsequence
   a_ack_next: assert property (disable iff (rst_i) tk |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (disable iff (rst_i) wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (disable iff (rst_i) ce_i && !wb_stb_i |=> !wb_ack_o)
      else $error("ack without request");
   a_dat_idle: assert property (disable iff (rst_i) !wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_reset_clear: assert property (rst_i && ce_i |=> !wb_ack_o && !param_err_o && !life_fail_o)
      else $error("outputs not cleared by reset");
   a_res_bound: assert property (disable iff (rst_i)
      s_wr(EPP_A_RES) ##0 (wb_dat_i == 32'h0 || wb_dat_i > 32'h2000) |=> param_err_o)
      else $error("bad resolution not flagged");
   a_tmr_low: assert property (disable iff (rst_i)
      s_wr(EPP_A_TMR) ##0 wb_dat_i < 32'h2 |=> param_err_o)
      else $error("bad range not flagged");
   a_err_keep: assert property (disable iff (rst_i) param_err_o && !wst |=> param_err_o)
      else $error("parameter error lost");
   a_err_cause: assert property (disable iff (rst_i)
      !param_err_o && !(tk && wb_we_i) |=> !param_err_o)
      else $error("parameter error without write");
   a_life_keep: assert property (disable iff (rst_i) life_fail_o && !wst |=> life_fail_o)
      else $error("life failure lost");
endmodule
bind epp_core epp_core_asserts epp_core_asserts_i (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .param_err_o, .life_fail_o);
`default_nettype wire

// ===== testbench/epp_core_tb.sv
// Self-checking bench for the encoder position core
`timescale 1ns/1ps
`default_nettype none
module epp_core_tb
   import epp_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [EPP_POS_BITS-1:0] pos = 29'h3456;
   logic tick = 1'b0;
   logic ok = 1'b1;
   logic ce = 1'b1;
   logic [EPP_POS_BITS-1:0] raw;
   logic ltick;
   logic lok;
   logic [31:0] rdat;
   logic ack;
   logic perr;
   logic lfail;
   int miscompares = 0;
   int n_tests = 0;
   epp_sensor_model epp_sensor_model_i (.clk_i(clk_i), .pos_i(pos), .tick_i(tick), .ok_i(ok),
      .raw_pos_o(raw), .life_tick_o(ltick), .life_ok_o(lok));
   epp_core epp_core_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .raw_pos_i(raw),
      .life_tick_i(ltick), .life_ok_i(lok), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .param_err_o(perr), .life_fail_o(lfail));
   // 20 MHz clock
   initial
   forever #25 clk_i = ~clk_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic single Wishbone cycle, held until ack
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      if (n >= 50)
         miscompares++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   // Config word: [4]preset both [3]scaling [2]ccw [1]V3.1 [0]class 4, life limit 1
   function automatic logic [31:0] cfg(input logic [4:0] b);
      return {23'h0, 1'b1, 3'h0, b};
   endfunction
   task automatic miss(input int n);
      repeat (n)
      begin
         @(posedge clk_i);
         tick <= 1'b1;
         ok <= 1'b0;
         @(posedge clk_i);
         tick <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
   endtask
   task automatic t_reset;
      rd(EPP_A_CFG, EPP_CFG_RST);
      rd(EPP_A_RES, 32'h2000);
      rd(EPP_A_TMR, 32'h2000_0000);
      rd(8'h20, 32'h0);
   endtask
   task automatic t_class;
      wr(EPP_A_CFG, cfg(5'b11001));
      wr(EPP_A_RES, 32'h1000);
      rd(EPP_A_POS1, 32'h1a2b);
      rd(EPP_A_POS2, 32'h1a2b);
      wr(EPP_A_CFG, cfg(5'b10001));
      rd(EPP_A_POS1, 32'h3456);
      wr(EPP_A_CFG, cfg(5'b11100));
      rd(EPP_A_POS1, 32'h3456);
   endtask
   task automatic t_dir;
      logic [31:0] a;
      logic [31:0] b;
      wr(EPP_A_RES, 32'h2000);
      wr(EPP_A_CFG, cfg(5'b11101));
      bus(1'b0, EPP_A_POS1, 32'h0, a);
      pos <= pos + 1'b1;
      repeat (3) @(posedge clk_i);
      bus(1'b0, EPP_A_POS1, 32'h0, b);
      chk(a - b, 32'h1);
      pos <= pos - 1'b1;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic t_preset;
      wr(EPP_A_CTRL, 32'h1);
      wr(EPP_A_CFG, cfg(5'b11000));
      wr(EPP_A_PRESET, 32'h40);
      rd(EPP_A_POS2, 32'h3456);
      wr(EPP_A_CFG, cfg(5'b11001));
      wr(EPP_A_PRESET, 32'h100);
      rd(EPP_A_POS1, 32'h100);
      rd(EPP_A_POS2, 32'h100);
      wr(EPP_A_RES, 32'h1000);
      rd(EPP_A_POS2, 32'h1a2b);
      wr(EPP_A_RES, 32'h2000);
      wr(EPP_A_PRESET, 32'h200);
      wr(EPP_A_TMR, 32'h1000_0000);
      rd(EPP_A_POS2, 32'h3456);
      wr(EPP_A_CFG, cfg(5'b01001));
      wr(EPP_A_PRESET, 32'h300);
      rd(EPP_A_POS1, 32'h3456);
      rd(EPP_A_POS2, 32'h300);
      wr(EPP_A_TMR, 32'h2000_0000);
      wr(EPP_A_CTRL, 32'h0);
      wr(EPP_A_CFG, cfg(5'b11011));
      wr(EPP_A_PRESET, 32'h280);
      rd(EPP_A_POS1, 32'h3456);
      rd(EPP_A_POS2, 32'h280);
   endtask
   task automatic t_err;
      logic [7:0] a [4] = '{EPP_A_RES, EPP_A_RES, EPP_A_TMR, EPP_A_TMR};
      logic [31:0] d [4] = '{32'h0, 32'h2001, 32'h1, 32'h1000_0001};
      wr(EPP_A_RES, 32'h1000);
      for (int i = 0; i < 4; i++)
      begin
         wr(a[i], d[i]);
         chk({31'h0, perr}, 32'h1);
         wr(EPP_A_STAT, 32'h6);
         chk({31'h0, perr}, 32'h0);
      end
      rd(EPP_A_RES, 32'h1000);
      rd(EPP_A_TMR, 32'h2000_0000);
      wr(EPP_A_RES, 32'h2000);
      wr(EPP_A_CTRL, 32'h1);
      rd(EPP_A_STAT, 32'h0);
      wr(EPP_A_CFG, cfg(5'b11001));
      rd(EPP_A_STAT, 32'h1);
      wr(EPP_A_RES, 32'h1000);
      wr(EPP_A_TMR, 32'h1000);
      rd(EPP_A_POS1, 32'h0000_0a2b);
   endtask
   task automatic t_life;
      miss(2);
      chk({31'h0, lfail}, 32'h0);
      wr(EPP_A_CFG, cfg(5'b11011));
      miss(1);
      chk({31'h0, lfail}, 32'h0);
      miss(1);
      chk({31'h0, lfail}, 32'h1);
      wr(EPP_A_STAT, 32'h4);
      chk({31'h0, lfail}, 32'h0);
      // Clock enable low freezes the failure counter
      ce <= 1'b0;
      miss(1);
      chk({31'h0, lfail}, 32'h0);
      ce <= 1'b1;
      miss(1);
      chk({31'h0, lfail}, 32'h1);
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Main sequence after reset
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_class;
      t_dir;
      t_preset;
      t_err;
      t_life;
      close_out;
   end
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      close_out;
   end
endmodule
`default_nettype wire

// ===== testbench/epp_sensor_model.sv
// Sensing unit and sign-of-life source model
`timescale 1ns/1ps
`default_nettype none
module epp_sensor_model
   import epp_pkg::*;
(
   input wire logic clk_i,
   input wire logic [EPP_POS_BITS-1:0] pos_i,
   input wire logic tick_i,
   input wire logic ok_i,
   output logic [EPP_POS_BITS-1:0] raw_pos_o,
   output logic life_tick_o,
   output logic life_ok_o
);
   // Shaft position, check event, status garbled outside events
   always_ff @(posedge clk_i)
   begin
      raw_pos_o <= pos_i;
      life_tick_o <= tick_i;
      life_ok_o <= tick_i ? ok_i : ~ok_i;
   end
endmodule
`default_nettype wire
